/* File: inc/serial_load_pkg.sv */
// shared constants and carrier types for the serial load port
// Behaviour
// - Select falling starts a word; bit count restarts for each new word.
// - While select low, sample serial input on rising bit clock, MSB first.
// - Latch loads on the bit-clock falling edge right after the 16th rise.
// - After the update further clocking is ignored until select rises and falls.
// - Select high before the update discards the partial word, latch unchanged.
// - While select high, bit clock and serial input are ignored entirely.
// - Clear low during the 16th cycle loads midcode instead of shifted word.
// - Clear high during the 16th cycle loads the shifted word.
// - Midcode stays after clear returns high until the next update edge.
// - Clear never disturbs shifting; the incoming word keeps accumulating.
// - Latched word is twos complement: 7fff plus full, 0000 zero, 8000 minus.
package serial_load_pkg;
    localparam int WORD_BITS = 16;
    localparam int COUNT_BITS = 5;
    localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;
    localparam logic [COUNT_BITS-1:0] COUNT_ONE = 5'h01;
    localparam logic [COUNT_BITS-1:0] COUNT_FULL = 5'h10;
    localparam logic [WORD_BITS-1:0] MIDCODE = 16'h0000;
    localparam logic [WORD_BITS-1:0] POS_FULL = 16'h7fff;
    localparam logic [WORD_BITS-1:0] NEG_FULL = 16'h8000;
    localparam int SYS_CLK_MHZ = 25;
    localparam int LINK_MAX_MHZ = 50;

    // sampled link pins after synchronisation
    typedef struct packed {
        logic selectN;
        logic bitClk;
        logic serialIn;
        logic clearN;
    } link_pins_t;

    // edge events found on the sampled link
    typedef struct packed {
        logic selectFall;
        logic selectHigh;
        logic clkRise;
        logic clkFall;
    } link_events_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_ARMED = 2'b10,
        ST_DONE = 2'b11
    } load_state_t;
endpackage

/* File: rtl/pin_sync.sv */
// two-stage synchroniser for the link pins
`timescale 1ns/1ns
module pin_sync (
    input wire logic clk_sys,
    input wire logic reset,
    input wire serial_load_pkg::link_pins_t rawPins,
    output serial_load_pkg::link_pins_t syncPins
);
    serial_load_pkg::link_pins_t stage1;

    // idle levels: select high, clear high, clock low
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stage1 <= '{selectN: 1'b1, bitClk: 1'b0, serialIn: 1'b0, clearN: 1'b1};
            syncPins <= '{selectN: 1'b1, bitClk: 1'b0, serialIn: 1'b0, clearN: 1'b1};
        end else begin
            stage1 <= rawPins;
            syncPins <= stage1; // first stage feeds nothing else
        end
    end
endmodule // pin_sync

/* File: rtl/edge_find.sv */
// edge detection on the synchronised link pins
`timescale 1ns/1ns
module edge_find (
    input wire logic clk_sys,
    input wire logic reset,
    input wire serial_load_pkg::link_pins_t pins,
    output serial_load_pkg::link_events_t events
);
    logic lastSelectN;
    logic lastBitClk;

    // previous levels
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lastSelectN <= 1'b1;
            lastBitClk <= 1'b0;
        end else begin
            lastSelectN <= pins.selectN;
            lastBitClk <= pins.bitClk;
        end
    end

    // edge events are one-cycle pulses; selectHigh follows the select level itself
    always_comb begin
        events.selectFall = lastSelectN & ~pins.selectN;
        events.selectHigh = pins.selectN;
        events.clkRise = ~lastBitClk & pins.bitClk & ~pins.selectN;
        events.clkFall = lastBitClk & ~pins.bitClk & ~pins.selectN;
    end
endmodule // edge_find

/* File: rtl/serial_load.sv */
// serial word receiver and output latch with midscale clear
`timescale 1ns/1ns
module serial_load #(
    parameter int WORD_BITS = serial_load_pkg::WORD_BITS
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic selectN,
    input wire logic bitClk,
    input wire logic serial_in_line,
    input wire logic force_midscale_n,
    output logic [WORD_BITS-1:0] latchWord,
    output logic latchUpdate,
    output logic latchCleared,
    output logic busy
);
    // sampling needs at least four system clocks per bit clock period;
    // the bench bit clock of 320 ns gives eight, the pin maximum is out of reach
    if (WORD_BITS != serial_load_pkg::WORD_BITS) begin : g_width_check
        $error("serial_load supports only the fixed word width");
    end

    // the counter must hold the full word count without wrapping to zero
    if ((1 << serial_load_pkg::COUNT_BITS) <= serial_load_pkg::WORD_BITS) begin : g_count_check
        $error("serial_load bit counter too narrow for the word width");
    end

    serial_load_pkg::link_pins_t rawPins;
    serial_load_pkg::link_pins_t pins;
    serial_load_pkg::link_events_t ev;
    serial_load_pkg::load_state_t state;
    serial_load_pkg::load_state_t next_state;
    logic [serial_load_pkg::COUNT_BITS-1:0] bitCount;
    logic [WORD_BITS-1:0] shiftWord;
    logic clearSeen;
    logic shiftEdge;
    logic armEdge;
    logic loadEdge;
    logic clearNow;
    logic loadCleared;

    // true on the rise that completes the word; the count still shows the bits before it
    function automatic logic isLastRise(
        input logic rise,
        input logic [serial_load_pkg::COUNT_BITS-1:0] count
    );
        return rise && (count == serial_load_pkg::COUNT_FULL - serial_load_pkg::COUNT_ONE);
    endfunction

    // new bit enters at the bottom, so the first bit sent ends up as the msb
    function automatic logic [WORD_BITS-1:0] shiftOne(
        input logic [WORD_BITS-1:0] word,
        input logic bitIn
    );
        return {word[WORD_BITS-2:0], bitIn};
    endfunction

    // value the latch takes at an update; a clear seen in the window wins
    function automatic logic [WORD_BITS-1:0] loadValue(
        input logic cleared,
        input logic [WORD_BITS-1:0] word
    );
        if (cleared) begin
            return serial_load_pkg::MIDCODE;
        end
        return word;
    endfunction

    // qualifiers decoded once so every register acts on the same edge
    assign shiftEdge = (state == serial_load_pkg::ST_SHIFT) && ev.clkRise;
    assign armEdge = (state == serial_load_pkg::ST_SHIFT) &&
                     (next_state == serial_load_pkg::ST_ARMED);
    assign loadEdge = (state == serial_load_pkg::ST_ARMED) &&
                      (next_state == serial_load_pkg::ST_DONE);
    assign clearNow = ~pins.clearN;
    // the sample at the fall itself counts, so a clear at the last moment is not missed
    assign loadCleared = clearSeen || clearNow;

    assign rawPins = '{selectN: selectN, bitClk: bitClk,
                       serialIn: serial_in_line, clearN: force_midscale_n};

    pin_sync u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .rawPins(rawPins),
        .syncPins(pins)
    );

    edge_find u_edge (
        .clk_sys(clk_sys),
        .reset(reset),
        .pins(pins),
        .events(ev)
    );

    // sequence control; select fall always restarts, select high always aborts
    always_comb begin
        next_state = state;
        case (state)
            serial_load_pkg::ST_IDLE: begin
                if (ev.selectFall) begin
                    next_state = serial_load_pkg::ST_SHIFT;
                end
            end
            serial_load_pkg::ST_SHIFT: begin
                if (ev.selectHigh) begin
                    next_state = serial_load_pkg::ST_IDLE;
                end else if (isLastRise(ev.clkRise, bitCount)) begin
                    next_state = serial_load_pkg::ST_ARMED;
                end
            end
            serial_load_pkg::ST_ARMED: begin
                if (ev.selectHigh) begin
                    next_state = serial_load_pkg::ST_IDLE;
                end else if (ev.clkFall) begin
                    next_state = serial_load_pkg::ST_DONE;
                end
            end
            serial_load_pkg::ST_DONE: begin
                if (ev.selectHigh) begin
                    next_state = serial_load_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = serial_load_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= serial_load_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit counter restarts on every select fall
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bitCount <= serial_load_pkg::COUNT_ZERO;
        end else if (ev.selectFall || ev.selectHigh) begin
            bitCount <= serial_load_pkg::COUNT_ZERO;
        end else if (shiftEdge) begin
            bitCount <= bitCount + serial_load_pkg::COUNT_ONE;
        end
    end

    // shift register; clear has no say here so the word keeps building
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            shiftWord <= serial_load_pkg::MIDCODE;
        end else if (shiftEdge) begin
            shiftWord <= shiftOne(shiftWord, pins.serialIn);
        end
    end

    // clear level captured across the 16th bit cycle, from its rise to its fall;
    // sticky, so a clear pulse shorter than the bit still counts
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clearSeen <= 1'b0;
        end else if (armEdge) begin
            clearSeen <= clearNow;
        end else if (state == serial_load_pkg::ST_ARMED && clearNow) begin
            clearSeen <= 1'b1;
        end
    end

    // output latch; holds between updates whatever clear does meanwhile
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            latchWord <= serial_load_pkg::MIDCODE;
        end else if (loadEdge) begin
            latchWord <= loadValue(loadCleared, shiftWord);
        end
    end

    // midcode flag kept in step with the latch word
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            latchCleared <= 1'b1;
        end else if (loadEdge) begin
            latchCleared <= loadCleared;
        end
    end

    // one pulse per latch update, in the cycle the new word first shows
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            latchUpdate <= 1'b0;
        end else begin
            latchUpdate <= loadEdge;
        end
    end

    assign busy = (state == serial_load_pkg::ST_SHIFT) || (state == serial_load_pkg::ST_ARMED);
endmodule // serial_load

/* File: verif/serial_load_checker.sv */
// checker of the serial load port outputs
`timescale 1ns/1ns
module serial_load_checker #(
    parameter int WORD_BITS = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic selectN,
    input wire logic force_midscale_n,
    input wire logic [WORD_BITS-1:0] latchWord,
    input wire logic latchUpdate,
    input wire logic latchCleared,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_word_holds: assert property ($changed(latchWord) |-> latchUpdate)
        else $error("latch changed without update pulse");
    chk_pulse_single: assert property (latchUpdate |=> !latchUpdate)
        else $error("update pulse longer than one cycle");
    // eight idle cycles are enough for the pin synchroniser to drain
    chk_idle_quiet: assert property (selectN[*8] |-> !busy && !latchUpdate)
        else $error("activity while select high");
    chk_start_busy: assert property ($fell(selectN) ##1 (!selectN)[*4] |-> busy)
        else $error("word not started after select fall");
    chk_update_busy: assert property (latchUpdate |-> !busy && $past(busy, 4))
        else $error("update without a word in progress");
    chk_clear_midcode: assert property (latchCleared |-> latchWord == '0)
        else $error("cleared latch not at midcode");
    chk_clear_loads: assert property ((!force_midscale_n)[*8] ##0 latchUpdate |-> latchCleared)
        else $error("clear low but word loaded");
    chk_word_loads: assert property (force_midscale_n[*8] ##0 latchUpdate |-> !latchCleared)
        else $error("clear high but midcode loaded");
    chk_reset_state: assert property ($fell(reset) |-> latchWord == '0 && latchCleared && !busy)
        else $error("wrong state after reset");
endmodule // serial_load_checker
bind serial_load serial_load_checker #(.WORD_BITS(WORD_BITS)) i_checker (
    .clk_sys(clk_sys), .reset(reset), .selectN(selectN), .force_midscale_n(force_midscale_n),
    .latchWord(latchWord), .latchUpdate(latchUpdate), .latchCleared(latchCleared), .busy(busy)
);

/* File: verif/host_link_model.sv */
// host model writing words over the three-wire link
`timescale 1ns/1ns
module host_link_model (
    input wire logic clk_sys,
    output logic selectN,
    output logic bitClk,
    output logic serialIn,
    output logic clearN
);
    initial begin
        selectN = 1'b1;
        bitClk = 1'b0;
        serialIn = 1'b0;
        clearN = 1'b1;
    end
    // bit clock 320 ns, well under the port limit; still between calls, but it also runs with select held high when keepHigh is set
    task automatic send(input logic [15:0] w, input logic [15:0] midMask, input int nBits,
                        input logic keepHigh);
        int i;
        selectN <= keepHigh;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < nBits; i++) begin
            serialIn <= w[15 - (i % 16)];
            clearN <= midMask[15 - (i % 16)];
            repeat (4) @(posedge clk_sys);
            bitClk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            bitClk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        selectN <= 1'b1;
        serialIn <= ~serialIn; // released line must not keep the last bit
        clearN <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule // host_link_model

/* File: verif/dac_serial_load_and_clear_test.sv */
// self-checking bench for the serial load port
`timescale 1ns/1ns
module dac_serial_load_and_clear_test;
    typedef struct packed {
        logic [15:0] word;
        logic [15:0] midMask;
        logic [15:0] expWord;
        logic expCleared;
    } row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic selectN, bitClk, serialIn, clearN, latchUpdate, latchCleared, busy;
    logic [15:0] latchWord;
    int fail_count = 0;
    int n_compared = 0;
    int nUpd = 0;
    int i;
    // last two rows: clear low only early, then clear low only in the last bit
    row_t rows [7] = '{'{16'h7fff, 16'hffff, 16'h7fff, 1'b0}, '{16'h8000, 16'hffff, 16'h8000, 1'b0},
        '{16'h4000, 16'hffff, 16'h4000, 1'b0}, '{16'hbfff, 16'hffff, 16'hbfff, 1'b0},
        '{16'h0000, 16'hffff, 16'h0000, 1'b0}, '{16'ha5c3, 16'h0001, 16'ha5c3, 1'b0},
        '{16'h1234, 16'hfffe, 16'h0000, 1'b1}};
    serial_load i_dut (
        .clk_sys(clk_sys), .reset(reset), .selectN(selectN), .bitClk(bitClk),
        .serial_in_line(serialIn), .force_midscale_n(clearN), .latchWord(latchWord),
        .latchUpdate(latchUpdate), .latchCleared(latchCleared), .busy(busy)
    );
    host_link_model i_host (
        .clk_sys(clk_sys), .selectN(selectN), .bitClk(bitClk), .serialIn(serialIn),
        .clearN(clearN)
    );
    always #20 clk_sys = ~clk_sys;
    // pulses are counted rather than awaited, so a missing one cannot hang the run
    always @(posedge clk_sys) begin
        if (latchUpdate === 1'b1) nUpd <= nUpd + 1;
    end
    task automatic check(input string name, input logic [15:0] w, input logic expMid,
                         input int upd);
        n_compared++;
        if (latchWord !== w || latchCleared !== expMid || nUpd !== upd) begin
            fail_count++;
            $display("BAD at %0t: %s latch %h cleared %b pulses %0d", $time, name, latchWord,
                     latchCleared, nUpd);
        end
        $display("done: %s", name);
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        check("reset", 16'h0000, 1'b1, 0);
        for (i = 0; i < 7; i++) begin
            i_host.send(rows[i].word, rows[i].midMask, 16, 1'b0);
            check("row", rows[i].expWord, rows[i].expCleared, i + 1);
        end
        i_host.send(16'hffff, 16'hffff, 16, 1'b1);
        check("select high", 16'h0000, 1'b1, 7);
        i_host.send(16'h5555, 16'hffff, 10, 1'b0);
        check("abort", 16'h0000, 1'b1, 7);
        i_host.send(16'h0f0f, 16'hffff, 20, 1'b0);
        check("extra clocks", 16'h0f0f, 1'b0, 8);
        i_host.send(16'hc3a5, 16'hffff, 16, 1'b0);
        check("restart", 16'hc3a5, 1'b0, 9);
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        check("second reset", 16'h0000, 1'b1, 9);
        wrap_up();
    end
endmodule // dac_serial_load_and_clear_test
